/* File: hdl/torque_limiter_pkg.sv */
// Constants, register map and state types of the torque-mode speed limiter.
// Assumes a single 250 MHz clock and a plain one-cycle strobe register port.
`default_nettype none
package torque_limiter_pkg;

  // Clock and timing.
  localparam int CLK_PERIOD_NS  = 4;
  localparam int FILT_STEP_NS   = 10000;
  localparam int FILT_STEP_CYC  = FILT_STEP_NS / CLK_PERIOD_NS;
  localparam int HOLD_TIME_MS   = 1000;
  localparam int HOLD_CYC       = HOLD_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int FLASH_TIME_MS  = 1000;
  localparam int FLASH_CYC      = FLASH_TIME_MS * 1000000 / CLK_PERIOD_NS;

  // Register byte offsets.
  localparam logic [7:0] REG_CTRL        = 8'h00;
  localparam logic [7:0] REG_FILT_TIME   = 8'h04;
  localparam logic [7:0] REG_SPEED_LIMIT = 8'h08;
  localparam logic [7:0] REG_REF_GAIN    = 8'h0C;
  localparam logic [7:0] REG_MAX_SPEED   = 8'h10;
  localparam logic [7:0] REG_OVERSPEED   = 8'h14;
  localparam logic [7:0] REG_RATED_SPEED = 8'h18;
  localparam logic [7:0] REG_OFFSET      = 8'h1C;
  localparam logic [7:0] REG_IRQ_STATUS  = 8'h20;
  localparam logic [7:0] REG_IRQ_CLEAR   = 8'h24;
  localparam logic [7:0] REG_IRQ_ENABLE  = 8'h28;
  localparam logic [7:0] REG_LIVE        = 8'h2C;
  localparam logic [7:0] REG_EFF_LIMIT   = 8'h30;
  localparam logic [7:0] REG_PARAM_INIT  = 8'h34;

  // Control and live register fields.
  localparam int CTRL_SRC_BIT     = 0;
  localparam int CTRL_CEIL_BIT    = 1;
  localparam int CTRL_WPROT_BIT   = 2;
  localparam int LIVE_FLAG_BIT    = 0;
  localparam int LIVE_STATE_LSB   = 4;

  // Reset values and ranges.
  localparam logic [15:0] FILT_TIME_RST   = 16'h0000;
  localparam logic [15:0] SPEED_LIMIT_RST = 16'h2710;
  localparam logic [15:0] SPEED_LIMIT_MAX = 16'h2710;
  localparam logic [15:0] REF_GAIN_RST    = 16'h0258;
  localparam logic [15:0] REF_GAIN_MIN    = 16'h0096;
  localparam logic [15:0] REF_GAIN_MAX    = 16'h0BB8;
  localparam logic [15:0] GAIN_STEP_MV    = 16'h000A;
  localparam logic [15:0] MAX_SPEED_RST   = 16'h1770;
  localparam logic [15:0] OVERSPEED_RST   = 16'h19C8;
  localparam logic [15:0] RATED_SPEED_RST = 16'h0BB8;

  // Interrupt event bits.
  localparam int EV_W       = 3;
  localparam int EV_LIMIT   = 0;
  localparam int EV_DONE    = 1;
  localparam int EV_REFUSED = 2;

  typedef enum logic [2:0] {
    T_SELECT, T_AUTO, T_MAN_WAIT, T_MAN_READY, T_MAN_EDIT, T_DONE, T_REFUSED
  } tune_e;

endpackage : torque_limiter_pkg
`default_nettype wire

/* File: hdl/seq_divider.sv */
// Unsigned restoring divider, one quotient bit per clock.
// Assumes start is only pulsed while busy is low; a zero divisor gives all ones.
`timescale 1ns/100ps
`default_nettype none
module seq_divider (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic [31:0] numer,
  input  wire logic [15:0] denom,
  output logic             busy,
  output logic             done,
  output logic [31:0]      quot,
  output logic [15:0]      remain
);
  logic [31:0] num_r;
  logic [16:0] rem_r;
  logic [15:0] den_r;
  logic [5:0]  cnt_r;
  logic [16:0] trial;

  assign trial = {rem_r[15:0], num_r[31]};

  always_ff @(posedge clk) begin
    if (rst) begin
      num_r <= 32'h0000_0000;
      rem_r <= 17'h0_0000;
      den_r <= 16'h0000;
      cnt_r <= 6'h00;
      busy  <= 1'b0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        num_r <= numer;
        den_r <= denom;
        rem_r <= 17'h0_0000;
        cnt_r <= 6'h20;
        busy  <= 1'b1;
      end else if (busy) begin
        if (trial >= {1'b0, den_r}) begin
          rem_r <= trial - {1'b0, den_r};
          num_r <= {num_r[30:0], 1'b1};
        end else begin
          rem_r <= trial;
          num_r <= {num_r[30:0], 1'b0};
        end
        cnt_r <= cnt_r - 6'h01;
        if (cnt_r == 6'h01) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

  assign quot   = num_r;
  assign remain = rem_r[15:0];
endmodule : seq_divider
`default_nettype wire

/* File: hdl/torque_mode_speed_limiter.sv */
// Torque reference smoothing, offset tuning and speed limiting in torque control.
// Assumes all inputs are synchronous to clk; analog inputs arrive as signed mV
// samples, motor speed as signed rpm, panel keys as clean levels.
//
// The address map and strobed register access were decided locally.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - The torque reference is lag filtered with a 0.01 ms step constant, zero disabling it.
// - The torque command follows the reference and speed is only touched by the speed limit.
// - The speed-limited flag is high while the limit clamps the motor and low otherwise.
// - Source 0 (default) selects the internal setpoint and source 1 the gained analog input.
// - Internal limiting takes the lesser of the setpoint and max speed (0) or overspeed (1).
// - The internal limit setpoint takes 0 to 10000 rpm, defaults to 10000 and acts at once.
// - With external limiting the lesser of the analog-derived speed and the setpoint is used.
// - The external limit uses only the magnitude of the analog input.
// - Gain spans 150 to 3000 in 10 mV steps and an input at the gain gives rated speed.
// - Manual tuning is refused with a not-operable display while write protection is on.
// - Parameter initialisation leaves the stored offset untouched.
// - Manual tuning shows the bias, up and down adjust it, mode stores it and flashes done.
// - In auto tuning the mode key stores the measured offset, then flashes done for a second.
// - A one second data key hold enters the utility and, once done, returns to selection.
module torque_mode_speed_limiter
  import torque_limiter_pkg::*;
#(
  parameter int HOLD_CYCLES  = HOLD_CYC,
  parameter int FLASH_CYCLES = FLASH_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic [31:0]      regRdata,
  input  wire logic [15:0] torqueRefIn,
  input  wire logic [15:0] speedLimitIn,
  input  wire logic [15:0] motorSpeed,
  input  wire logic        servoOn,
  input  wire logic        keyUp,
  input  wire logic        keyDown,
  input  wire logic        modeKey,
  input  wire logic        keyData,
  output logic [15:0]      torqueCmd,
  output logic             speedLimitedFlag,
  output logic [2:0]       dispState,
  output logic [15:0]      dispBias,
  output logic             dispFlash,
  output logic             notOperableDisplay,
  output logic             irq
);
  logic        limitSourceSelect_r;
  logic        limitCeilingSelect_r;
  logic        writeProtect_r;
  logic [15:0] torqueRefFilterTime_r;
  logic [15:0] torqueModeSpeedLimit_r;
  logic [15:0] speedRefGain_r;
  logic [15:0] maxSpeed_r;
  logic [15:0] overspeed_r;
  logic [15:0] ratedSpeed_r;
  logic [15:0] offset_r;
  logic [15:0] editBias_r;
  logic [EV_W-1:0] irqStatus_r;
  logic [EV_W-1:0] irqEnable_r;
  logic [EV_W-1:0] events;
  logic        wrHit;
  logic        paramInit;
  logic [15:0] wdata16;
  tune_e       tune_r;
  logic        utilManual_r;

  assign wdata16   = regWdata[15:0];
  assign wrHit     = regWr;
  assign paramInit = regWr && (regAddr == REG_PARAM_INIT);

  // Parameter registers; initialisation restores them but never the offset.
  always_ff @(posedge clk) begin
    if (rst || paramInit) begin
      limitSourceSelect_r    <= 1'b0;
      limitCeilingSelect_r   <= 1'b0;
      writeProtect_r         <= 1'b0;
      torqueRefFilterTime_r  <= FILT_TIME_RST;
      torqueModeSpeedLimit_r <= SPEED_LIMIT_RST;
      speedRefGain_r         <= REF_GAIN_RST;
      maxSpeed_r             <= MAX_SPEED_RST;
      overspeed_r            <= OVERSPEED_RST;
      ratedSpeed_r           <= RATED_SPEED_RST;
    end else if (wrHit) begin
      case (regAddr)
        REG_CTRL: begin
          limitSourceSelect_r  <= regWdata[CTRL_SRC_BIT];
          limitCeilingSelect_r <= regWdata[CTRL_CEIL_BIT];
          writeProtect_r       <= regWdata[CTRL_WPROT_BIT];
        end
        REG_FILT_TIME:   torqueRefFilterTime_r <= wdata16;
        REG_SPEED_LIMIT: torqueModeSpeedLimit_r <= (wdata16 > SPEED_LIMIT_MAX) ?
                                                   SPEED_LIMIT_MAX : wdata16;
        REG_REF_GAIN: begin
          if (wdata16 < REF_GAIN_MIN)      speedRefGain_r <= REF_GAIN_MIN;
          else if (wdata16 > REF_GAIN_MAX) speedRefGain_r <= REF_GAIN_MAX;
          else                             speedRefGain_r <= wdata16;
        end
        REG_MAX_SPEED:   maxSpeed_r <= wdata16;
        REG_OVERSPEED:   overspeed_r <= wdata16;
        REG_RATED_SPEED: ratedSpeed_r <= wdata16;
        default: ;
      endcase
    end
  end

  // External limit: |V| * rated / (gain * 10 mV), recomputed continuously.
  logic [15:0] vMag;
  logic [15:0] gainMv;
  logic        extBusy;
  logic        extDone;
  logic [31:0] extQuot;
  logic [15:0] extLimit_r;

  assign vMag   = speedLimitIn[15] ? 16'(-speedLimitIn) : speedLimitIn;
  assign gainMv = 16'(speedRefGain_r * GAIN_STEP_MV);

  seq_divider extDiv (
    .clk    (clk),
    .rst    (rst),
    .start  (!extBusy),
    .numer  (32'(vMag) * 32'(ratedSpeed_r)),
    .denom  (gainMv),
    .busy   (extBusy),
    .done   (extDone),
    .quot   (extQuot),
    .remain ()
  );

  always_ff @(posedge clk) begin
    if (rst) extLimit_r <= 16'h0000;
    else if (extDone) extLimit_r <= (extQuot[31:16] != 16'h0000) ? 16'hFFFF : extQuot[15:0];
  end

  logic [15:0] ceilSpeed;
  logic [15:0] intLimit;
  logic [15:0] extEff;
  logic [15:0] effLimit;

  assign ceilSpeed = limitCeilingSelect_r ? overspeed_r : maxSpeed_r;
  assign intLimit  = (ceilSpeed < torqueModeSpeedLimit_r) ? ceilSpeed : torqueModeSpeedLimit_r;
  assign extEff    = (extLimit_r < torqueModeSpeedLimit_r) ? extLimit_r
                                                           : torqueModeSpeedLimit_r;
  assign effLimit  = limitSourceSelect_r ? extEff : intLimit;

  // Offset correction feeding the lag filter, saturated to 16 bits.
  logic signed [16:0] corrected;
  logic signed [15:0] filtIn;
  assign corrected = $signed({torqueRefIn[15], torqueRefIn}) - $signed({offset_r[15], offset_r});
  assign filtIn    = (corrected > 17'sh07FFF) ? 16'sh7FFF :
                     (corrected < -17'sh08000) ? 16'sh8000 : corrected[15:0];

  // Lag filter: each 10 us step adds (x - y) / T with the remainder carried.
  // A divider avoids a multiplier per time constant at the cost of 33 cycles.
  logic [11:0]        stepCnt_r;
  logic               stepTick;
  logic signed [15:0] filtOut_r;
  logic signed [16:0] filtRem_r;
  logic signed [17:0] filtAcc;
  logic signed [17:0] filtAcc_r;
  logic               fltBusy;
  logic               fltDone;
  logic [31:0]        fltQuot;
  logic [15:0]        fltRemain;
  logic signed [17:0] stepDelta;

  assign stepTick = (stepCnt_r == 12'(FILT_STEP_CYC - 1));
  assign filtAcc  = 18'(filtRem_r) + 18'(filtIn) - 18'(filtOut_r);

  always_ff @(posedge clk) begin
    if (rst || stepTick) stepCnt_r <= 12'h000;
    else stepCnt_r <= stepCnt_r + 12'h001;
  end

  seq_divider fltDiv (
    .clk    (clk),
    .rst    (rst),
    .start  (stepTick && torqueRefFilterTime_r != 16'h0000),
    .numer  (32'(filtAcc[17] ? -filtAcc : filtAcc)),
    .denom  (torqueRefFilterTime_r),
    .busy   (fltBusy),
    .done   (fltDone),
    .quot   (fltQuot),
    .remain (fltRemain)
  );

  assign stepDelta = filtAcc_r[17] ? -18'(fltQuot[17:0]) : 18'(fltQuot[17:0]);

  always_ff @(posedge clk) begin
    if (rst) begin
      filtOut_r <= 16'sh0000;
      filtRem_r <= 17'sh0_0000;
      filtAcc_r <= 18'sh0_0000;
    end else if (torqueRefFilterTime_r == 16'h0000) begin
      filtOut_r <= filtIn;
      filtRem_r <= 17'sh0_0000;
    end else if (stepTick && !fltBusy) begin
      filtAcc_r <= filtAcc;
    end else if (fltDone) begin
      filtOut_r <= 16'(18'(filtOut_r) + stepDelta);
      filtRem_r <= filtAcc_r[17] ? -17'({1'b0, fltRemain}) : 17'({1'b0, fltRemain});
    end
  end

  // Speed clamp: torque that pushes the motor past the limit is withheld.
  logic [15:0] speedMag;
  logic        overLimit;
  logic        pushing;
  logic        clamping;

  assign speedMag  = motorSpeed[15] ? 16'(-motorSpeed) : motorSpeed;
  assign overLimit = speedMag >= effLimit;
  assign pushing   = (filtOut_r != 16'sh0000) && (filtOut_r[15] == motorSpeed[15]);
  assign clamping  = overLimit && pushing;

  always_ff @(posedge clk) begin
    if (rst) begin
      torqueCmd        <= 16'h0000;
      speedLimitedFlag <= 1'b0;
    end else begin
      torqueCmd        <= clamping ? 16'h0000 : filtOut_r;
      speedLimitedFlag <= clamping;
    end
  end

  // Panel keys: edges for up, down and mode; data acts after a one second hold.
  logic        upPrev_r;
  logic        downPrev_r;
  logic        modePrev_r;
  logic [31:0] holdCnt_r;
  logic        upPress;
  logic        downPress;
  logic        modePress;
  logic        holdFire;
  logic [31:0] flashCnt32_r;

  assign upPress   = keyUp && !upPrev_r;
  assign downPress = keyDown && !downPrev_r;
  assign modePress = modeKey && !modePrev_r;
  assign holdFire  = keyData && (holdCnt_r == 32'(HOLD_CYCLES - 1));

  always_ff @(posedge clk) begin
    if (rst) begin
      upPrev_r   <= 1'b0;
      downPrev_r <= 1'b0;
      modePrev_r <= 1'b0;
      holdCnt_r  <= 32'h0000_0000;
    end else begin
      upPrev_r   <= keyUp;
      downPrev_r <= keyDown;
      modePrev_r <= modeKey;
      if (!keyData) holdCnt_r <= 32'h0000_0000;
      else if (holdCnt_r != 32'(HOLD_CYCLES)) holdCnt_r <= holdCnt_r + 32'h0000_0001;
    end
  end

  // Offset tuning sequencer.
  always_ff @(posedge clk) begin
    if (rst) begin
      tune_r       <= T_SELECT;
      utilManual_r <= 1'b0;
      offset_r     <= 16'h0000;
      editBias_r   <= 16'h0000;
      flashCnt32_r <= 32'h0000_0000;
    end else begin
      if (flashCnt32_r != 32'h0000_0000) flashCnt32_r <= flashCnt32_r - 32'h0000_0001;
      case (tune_r)
        T_SELECT: begin
          if (upPress || downPress) utilManual_r <= !utilManual_r;
          else if (holdFire) begin
            if (writeProtect_r) tune_r <= T_REFUSED;
            else if (utilManual_r) tune_r <= T_MAN_WAIT;
            else if (servoOn) tune_r <= T_REFUSED;
            else tune_r <= T_AUTO;
          end
        end
        T_AUTO: begin
          if (modePress) begin
            offset_r     <= torqueRefIn;
            flashCnt32_r <= 32'(FLASH_CYCLES);
            tune_r       <= T_DONE;
          end
        end
        T_MAN_WAIT: if (servoOn) tune_r <= T_MAN_READY;
        T_MAN_READY: begin
          if (holdFire) begin
            editBias_r <= offset_r;
            tune_r     <= T_MAN_EDIT;
          end
        end
        T_MAN_EDIT: begin
          if (upPress) editBias_r <= editBias_r + 16'h0001;
          else if (downPress) editBias_r <= editBias_r - 16'h0001;
          else if (modePress) begin
            offset_r     <= editBias_r;
            flashCnt32_r <= 32'(FLASH_CYCLES);
            tune_r       <= T_DONE;
          end
        end
        T_DONE:    if (holdFire) tune_r <= T_SELECT;
        T_REFUSED: if (holdFire || modePress) tune_r <= T_SELECT;
        default:   tune_r <= T_SELECT;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dispState          <= 3'h0;
      dispBias           <= 16'h0000;
      dispFlash          <= 1'b0;
      notOperableDisplay <= 1'b0;
    end else begin
      dispState          <= tune_r;
      dispBias           <= (tune_r == T_MAN_EDIT) ? editBias_r : offset_r;
      dispFlash          <= flashCnt32_r != 32'h0000_0000;
      notOperableDisplay <= tune_r == T_REFUSED;
    end
  end

  // Interrupts: limit onset, tuning done, tuning refused. Set beats clear.
  logic tuneEnterDone;
  logic tuneEnterRefused;
  assign tuneEnterDone    = (tune_r == T_AUTO || tune_r == T_MAN_EDIT) && modePress;
  assign tuneEnterRefused = (tune_r == T_SELECT) && holdFire &&
                            (writeProtect_r || (!utilManual_r && servoOn));
  assign events = {tuneEnterRefused, tuneEnterDone, clamping && !speedLimitedFlag};

  always_ff @(posedge clk) begin
    if (rst) begin
      irqStatus_r <= '0;
      irqEnable_r <= '0;
    end else begin
      if (wrHit && regAddr == REG_IRQ_ENABLE) irqEnable_r <= regWdata[EV_W-1:0];
      if (wrHit && regAddr == REG_IRQ_CLEAR)
        irqStatus_r <= (irqStatus_r & ~regWdata[EV_W-1:0]) | events;
      else
        irqStatus_r <= irqStatus_r | events;
    end
  end

  assign irq = |(irqStatus_r & irqEnable_r);

  // Read port: data stand only in the cycle after the strobe.
  always_ff @(posedge clk) begin
    if (rst || !regRd) regRdata <= 32'h0000_0000;
    else begin
      case (regAddr)
        REG_CTRL:        regRdata <= 32'({writeProtect_r, limitCeilingSelect_r,
                                          limitSourceSelect_r});
        REG_FILT_TIME:   regRdata <= 32'(torqueRefFilterTime_r);
        REG_SPEED_LIMIT: regRdata <= 32'(torqueModeSpeedLimit_r);
        REG_REF_GAIN:    regRdata <= 32'(speedRefGain_r);
        REG_MAX_SPEED:   regRdata <= 32'(maxSpeed_r);
        REG_OVERSPEED:   regRdata <= 32'(overspeed_r);
        REG_RATED_SPEED: regRdata <= 32'(ratedSpeed_r);
        REG_OFFSET:      regRdata <= 32'(offset_r);
        REG_IRQ_STATUS:  regRdata <= 32'(irqStatus_r);
        REG_IRQ_ENABLE:  regRdata <= 32'(irqEnable_r);
        REG_LIVE:        regRdata <= 32'({tune_r, 3'h0, speedLimitedFlag});
        REG_EFF_LIMIT:   regRdata <= 32'(effLimit);
        default:         regRdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule : torque_mode_speed_limiter
`default_nettype wire

/* File: tb/torque_limiter_props.sv */
// Concurrent checks of the torque-mode speed limiter, bound onto its ports.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module torque_limiter_props #(
  parameter int FLASH_CYCLES = 10
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        keyUp,
  input wire logic        keyData,
  input wire logic        servoOn,
  input wire logic [15:0] torqueCmd,
  input wire logic        speedLimitedFlag,
  input wire logic [2:0]  dispState,
  input wire logic [15:0] dispBias,
  input wire logic        dispFlash
);
  int flashCnt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // A state seen just before a reset must not count as a move, hence the past reset terms.
  always_ff @(posedge clk) begin
    if (rst || !dispFlash) begin
      flashCnt <= 0;
    end else begin
      flashCnt <= flashCnt + 1;
    end
  end
  a_clamp_no_torque: assert property (speedLimitedFlag |-> torqueCmd == 16'h0)
    else $error("torque not withheld while limited");
  a_flash_length: assert property ($fell(dispFlash) |-> flashCnt >= FLASH_CYCLES &&
    flashCnt <= FLASH_CYCLES + 1) else $error("done flash has wrong length");
  a_flash_on_done: assert property ($rose(dispFlash) |-> ##[0:2] dispState == 3'h5)
    else $error("flash without done state");
  a_hold_entry: assert property ($past(dispState) == 3'h0 && dispState != 3'h0 &&
    !$past(rst) |-> $past(keyData, 3)) else $error("utility entered without key hold");
  a_done_return: assert property ($past(dispState) inside {3'h5, 3'h6} && !$past(rst) &&
    dispState != $past(dispState) |-> dispState == 3'h0) else $error("bad exit from done");
  a_edit_store: assert property ($past(dispState) == 3'h4 && dispState != 3'h4 &&
    !$past(rst) |-> dispState == 3'h5) else $error("edit left without store");
  a_wait_servo: assert property ($past(dispState) == 3'h2 && dispState != 3'h2 &&
    !$past(rst) |-> dispState == 3'h3 && $past(servoOn, 2)) else $error("ready without servo on");
  a_auto_store: assert property ($past(dispState) == 3'h1 && dispState != 3'h1 &&
    !$past(rst) |-> dispState == 3'h5) else $error("auto tuning left without store");
  a_edit_step: assert property ($rose(keyUp) && dispState == 3'h4 |=> ##[0:2]
    dispBias == $past(dispBias) + 16'h1) else $error("bias did not step up by one");
  c_done: cover property ($rose(dispFlash));
  c_refused: cover property (dispState == 3'h6);
  c_limited: cover property ($rose(speedLimitedFlag));
endmodule : torque_limiter_props
bind torque_mode_speed_limiter torque_limiter_props #(.FLASH_CYCLES(FLASH_CYCLES)) i_props (
  .clk(clk), .rst(rst), .keyUp(keyUp), .keyData(keyData), .servoOn(servoOn),
  .torqueCmd(torqueCmd), .speedLimitedFlag(speedLimitedFlag), .dispState(dispState),
  .dispBias(dispBias), .dispFlash(dispFlash)
);
`default_nettype wire

/* File: tb/upper_ctrl_model.sv */
// Upper controller model: analog references, speed feedback and servo state.
// Assumes the bench sets the wanted levels; the model adds what a real wire carries.
`timescale 1ns/100ps
`default_nettype none
module upper_ctrl_model #(
  parameter logic [15:0] BIAS_MV = 16'h0025
) (
  input  wire logic        zeroRef,
  input  wire logic        setServo,
  input  wire logic [15:0] setTorque,
  input  wire logic [15:0] setLimit,
  input  wire logic [15:0] setSpeed,
  output logic [15:0]      torqueRefIn,
  output logic [15:0]      speedLimitIn,
  output logic [15:0]      motorSpeed,
  output logic             servoOn
);
  // A zero-volt reference still arrives with a small sampling bias, which tuning must remove.
  always_comb begin
    torqueRefIn  = zeroRef ? BIAS_MV : setTorque;
    servoOn      = zeroRef ? 1'b0 : setServo;
    speedLimitIn = setLimit;
    motorSpeed   = setSpeed;
  end
endmodule : upper_ctrl_model
`default_nettype wire

/* File: tb/torque_mode_speed_limiter_tb.sv */
// Self-checking bench of the torque-mode speed limiter and its controller model.
// Assumes shortened hold and flash counts; register reads are checked from a queue.
`timescale 1ns/100ps
`default_nettype none
module torque_mode_speed_limiter_tb;
  import torque_limiter_pkg::*;
  localparam int          HOLD = 20;
  localparam logic [15:0] BIAS = 16'h0025;
  localparam logic [7:0]  RA [6] = '{REG_CTRL, REG_FILT_TIME, REG_SPEED_LIMIT, REG_REF_GAIN,
                                     REG_EFF_LIMIT, 8'h3C};
  localparam logic [31:0] RV [6] = '{32'h0, 32'h0, 32'h2710, 32'h0258, 32'h1770, 32'h0};
  logic        clk, rst, regWr, regRd, keyUp, keyDown, modeKey, keyData, zeroRef, setServo;
  logic        servoOn, speedLimitedFlag, dispFlash, notOperableDisplay, irq, rdSeen;
  logic [7:0]  regAddr;
  logic [31:0] regWdata, regRdata;
  logic [15:0] setTorque, setLimit, setSpeed, torqueRefIn, speedLimitIn, motorSpeed;
  logic [15:0] torqueCmd, dispBias, gain, mv;
  logic [2:0]  dispState;
  int          n_errors, n_checks;
  string       qName[$];
  logic [31:0] qVal[$];
  torque_mode_speed_limiter #(.HOLD_CYCLES(HOLD), .FLASH_CYCLES(10)) i_dut (
    .clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .torqueRefIn(torqueRefIn), .speedLimitIn(speedLimitIn),
    .motorSpeed(motorSpeed), .servoOn(servoOn), .keyUp(keyUp), .keyDown(keyDown),
    .modeKey(modeKey), .keyData(keyData), .torqueCmd(torqueCmd),
    .speedLimitedFlag(speedLimitedFlag), .dispState(dispState), .dispBias(dispBias),
    .dispFlash(dispFlash), .notOperableDisplay(notOperableDisplay), .irq(irq)
  );
  upper_ctrl_model #(.BIAS_MV(BIAS)) i_ctrl (
    .zeroRef(zeroRef), .setServo(setServo), .setTorque(setTorque), .setLimit(setLimit),
    .setSpeed(setSpeed), .torqueRefIn(torqueRefIn), .speedLimitIn(speedLimitIn),
    .motorSpeed(motorSpeed), .servoOn(servoOn)
  );
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, want, seen);
    end
  endtask : chk
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
    regWr    <= w;
    regRd    <= r;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clk);
  endtask : bus
  task automatic tick(input int n);
    repeat (n) bus(1'b0, 1'b0, 8'h00, 32'h0);
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask : wr
  task automatic rd(input string name, input logic [7:0] a, input logic [31:0] want);
    qName.push_back(name);
    qVal.push_back(want);
    bus(1'b0, 1'b1, a, 32'h0);
  endtask : rd
  task automatic hold();
    keyData <= 1'b1;
    tick(HOLD + 3);
    keyData <= 1'b0;
    tick(4);
  endtask : hold
  task automatic press(input logic [2:0] k);
    {keyUp, keyDown, modeKey} <= k;
    tick(2);
    {keyUp, keyDown, modeKey} <= 3'b000;
    tick(4);
  endtask : press
  function automatic logic [31:0] extLim(input logic [15:0] g, input logic [15:0] v);
    logic [31:0] m;
    m = {16'h0, v[15] ? 16'(-v) : v};
    m = m * {16'h0, RATED_SPEED_RST} / ({16'h0, g} * 32'hA);
    return (m < 32'h2710) ? m : 32'h2710;
  endfunction : extLim
  task automatic end_sim();
    if (n_errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim
  always @(posedge clk) begin
    if (rdSeen) chk(qName.pop_front(), regRdata, qVal.pop_front());
    rdSeen <= regRd;
  end
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    end_sim();
  end
  initial begin
    {rst, regWr, regRd, keyUp, keyDown, modeKey, keyData, zeroRef, setServo, rdSeen} = 10'h200;
    {regAddr, regWdata, setTorque, setLimit, setSpeed} = '0;
    void'($urandom(81601));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    tick(2);
    for (int i = 0; i < 6; i++) rd("reset value", RA[i], RV[i]);
    wr(REG_SPEED_LIMIT, 32'hFFFF);
    rd("limit ceiling", REG_SPEED_LIMIT, 32'h2710);
    wr(REG_SPEED_LIMIT, 32'h04D2);
    tick(2);
    rd("setpoint limit", REG_EFF_LIMIT, 32'h04D2);
    wr(REG_SPEED_LIMIT, 32'h2710);
    wr(REG_CTRL, 32'h2);
    tick(2);
    rd("overspeed limit", REG_EFF_LIMIT, {16'h0, OVERSPEED_RST});
    wr(REG_REF_GAIN, 32'h64);
    rd("gain floor", REG_REF_GAIN, 32'h96);
    wr(REG_CTRL, 32'h1);
    for (int i = 0; i < 6; i++) begin
      gain = (i == 0) ? 16'h0258 : 16'(32'h96 + $urandom % 2851);
      mv = (i == 0) ? 16'h1770 : (i == 1) ? 16'hE890 : 16'($urandom % 24001 - 12000);
      setLimit <= mv;
      wr(REG_REF_GAIN, {16'h0, gain});
      tick(80);
      rd("external limit", REG_EFF_LIMIT, extLim(gain, mv));
    end
    wr(REG_CTRL, 32'h0);
    wr(REG_SPEED_LIMIT, 32'h03E8);
    wr(REG_IRQ_ENABLE, 32'h1);
    setTorque <= 16'h01F4;
    setSpeed <= 16'h03E8;
    tick(6);
    rd("limited", REG_LIVE, 32'h1);
    rd("limit event", REG_IRQ_STATUS, 32'h1);
    chk("irq raised", {31'h0, irq}, 32'h1);
    wr(REG_IRQ_CLEAR, 32'h1);
    tick(2);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    setSpeed <= 16'h03E7;
    tick(4);
    rd("not limited", REG_LIVE, 32'h0);
    chk("torque follows", {16'h0, torqueCmd}, 32'h01F4);
    setSpeed <= 16'h0;
    setTorque <= 16'h0;
    tick(4);
    wr(REG_FILT_TIME, 32'h2);
    setTorque <= 16'h03E8;
    for (int i = 0; i < 3000 && torqueCmd === 16'h0; i++) tick(1);
    tick(50);
    chk("filter step", {16'h0, torqueCmd}, 32'h01F4);
    tick(2500);
    chk("filter second step", {16'h0, torqueCmd}, 32'h02EE);
    zeroRef <= 1'b1;
    hold();
    rd("auto state", REG_LIVE, 32'h10);
    press(3'b001);
    rd("auto done", REG_LIVE, 32'h50);
    rd("auto offset", REG_OFFSET, {16'h0, BIAS});
    hold();
    rd("select again", REG_LIVE, 32'h0);
    zeroRef <= 1'b0;
    press(3'b100);
    wr(REG_CTRL, 32'h4);
    hold();
    rd("refused", REG_LIVE, 32'h60);
    chk("not operable", {31'h0, notOperableDisplay}, 32'h1);
    press(3'b001);
    wr(REG_CTRL, 32'h0);
    hold();
    rd("wait servo", REG_LIVE, 32'h20);
    setServo <= 1'b1;
    tick(4);
    rd("servo ready", REG_LIVE, 32'h30);
    hold();
    repeat (3) press(3'b100);
    press(3'b010);
    rd("edit", REG_LIVE, 32'h40);
    chk("shown bias", {16'h0, dispBias}, {16'h0, BIAS + 16'h2});
    press(3'b001);
    rd("manual offset", REG_OFFSET, {16'h0, BIAS + 16'h2});
    hold();
    rd("tune events", REG_IRQ_STATUS, 32'h6);
    chk("irq masked", {31'h0, irq}, 32'h0);
    wr(REG_PARAM_INIT, 32'h1);
    tick(2);
    rd("offset kept", REG_OFFSET, {16'h0, BIAS + 16'h2});
    rd("limit restored", REG_SPEED_LIMIT, 32'h2710);
    tick(4);
    end_sim();
  end
endmodule : torque_mode_speed_limiter_tb
`default_nettype wire
